//--- hdl/tccc_pkg.sv
// Constants, register map and carrier types of the timer counter block
package tccc_pkg;
    // Register byte addresses, each register one aligned word
    localparam logic [7:0] MSC_OFS = 8'h00;
    localparam logic [7:0] CNTH_OFS = 8'h04;
    localparam logic [7:0] CNTL_OFS = 8'h08;
    localparam logic [7:0] MODH_OFS = 8'h0C;
    localparam logic [7:0] MODL_OFS = 8'h10;
    localparam logic [7:0] CH_BASE = 8'h20;
    localparam int CH_STRIDE_SH = 4;
    localparam logic [7:0] CH_SC_OFS = 8'h00;
    localparam logic [7:0] CH_VH_OFS = 8'h04;
    localparam logic [7:0] CH_VL_OFS = 8'h08;

    // Clock source codes
    localparam logic [1:0] CLKS_OFF = 2'h0;
    localparam logic [1:0] CLKS_BUS = 2'h1;
    localparam logic [1:0] CLKS_FIX = 2'h2;
    localparam logic [1:0] CLKS_EXT = 2'h3;

    // Edge/level codes
    localparam logic [1:0] ELS_NONE = 2'h0;
    localparam logic [1:0] ELS_RISE = 2'h1;
    localparam logic [1:0] ELS_FALL = 2'h2;
    localparam logic [1:0] ELS_BOTH = 2'h3;

    // Reset values and counter limits
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] MOD_RST = 16'h0000;
    localparam logic [15:0] TERM_FULL = 16'hFFFF;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [6:0] PRESC_RST = 7'h00;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Main status and control layout, bit 7 down to bit 0
    typedef struct packed {
        logic ovf;
        logic ovf_ie;
        logic center;
        logic [1:0] clk_src;
        logic [2:0] prescale;
    } tccc_main_ctl_t;

    // Channel status and control layout, bit 7 down to bit 2
    typedef struct packed {
        logic flag;
        logic irq_en;
        logic mode_b;
        logic mode_a;
        logic [1:0] els;
    } tccc_chan_ctl_t;

    // Channel operating modes
    typedef enum logic [3:0] {
        CH_CAPTURE = 4'h1,
        CH_COMPARE = 4'h2,
        CH_EPWM = 4'h4,
        CH_CPWM = 4'h8
    } tccc_chan_mode_t;
endpackage

//--- hdl/tccc_top.sv
// Timer counter with modulo, prescaler and capture/compare/PWM channels
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module tccc_top #(
    parameter int NUM_CH = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic external_timer_clock,
    input wire logic fixed_system_clock,
    input wire logic debug_active,
    input wire logic [NUM_CH-1:0] chan_pin_in,
    output logic [NUM_CH-1:0] chan_pin_out,
    output logic [NUM_CH-1:0] chan_pin_oe_n,
    output logic overflow_irq,
    output logic [NUM_CH-1:0] chan_irq
);
    tccc_pkg::tccc_main_ctl_t msc;
    tccc_pkg::tccc_chan_ctl_t ch_ctl [NUM_CH];
    logic [15:0] ch_val [NUM_CH];
    logic [15:0] cnt;
    logic [15:0] modulo;
    logic [15:0] cnt_buf;
    logic [15:0] term;
    logic [6:0] presc_cnt;
    logic [6:0] presc_mask;
    logic dir_down;
    logic cnt_latched;
    logic cnt_first_hi;
    logic mod_pend_h;
    logic mod_pend_l;
    logic ovf_arm;
    logic ext_s1, ext_s2, ext_s3;
    logic fix_s1, fix_s2, fix_s3;
    logic ext_edge, fix_edge;
    logic tick_src, tick, at_term, ovf_event, ovf_set;
    logic wr_fire, wr_en, rd_fire, wr_hit, rd_hit;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;
    logic wr_msc, wr_cnt, wr_modh, wr_modl, rd_msc, rd_cnth, rd_cntl;

    // Write taken only when address and data are both present
    assign wr_fire = awvalid && wvalid && !bvalid;
    assign awready = wr_fire;
    assign wready = wr_fire;
    assign wr_en = wr_fire && wstrb[0];
    assign wbyte = wdata[7:0];
    assign rd_fire = arvalid && !rvalid;
    assign arready = !rvalid;

    // Shared register decodes
    assign wr_msc = wr_en && (awaddr == tccc_pkg::MSC_OFS);
    assign wr_cnt = wr_en && (awaddr == tccc_pkg::CNTH_OFS || awaddr == tccc_pkg::CNTL_OFS);
    assign wr_modh = wr_en && (awaddr == tccc_pkg::MODH_OFS);
    assign wr_modl = wr_en && (awaddr == tccc_pkg::MODL_OFS);
    assign rd_msc = rd_fire && (araddr == tccc_pkg::MSC_OFS);
    assign rd_cnth = rd_fire && (araddr == tccc_pkg::CNTH_OFS);
    assign rd_cntl = rd_fire && (araddr == tccc_pkg::CNTL_OFS);

    // Address validity check shared by read and write answers
    function automatic logic addr_ok(input logic [7:0] a);
        logic ok;
        logic [7:0] rel;
        ok = (a == tccc_pkg::MSC_OFS) || (a == tccc_pkg::CNTH_OFS) ||
             (a == tccc_pkg::CNTL_OFS) || (a == tccc_pkg::MODH_OFS) ||
             (a == tccc_pkg::MODL_OFS);
        rel = a - tccc_pkg::CH_BASE;
        if (a >= tccc_pkg::CH_BASE && int'(rel >> tccc_pkg::CH_STRIDE_SH) < NUM_CH &&
            (rel[3:0] == tccc_pkg::CH_SC_OFS[3:0] || rel[3:0] == tccc_pkg::CH_VH_OFS[3:0] ||
             rel[3:0] == tccc_pkg::CH_VL_OFS[3:0])) begin
            ok = 1'b1;
        end
        return ok;
    endfunction
    assign wr_hit = addr_ok(awaddr);
    assign rd_hit = addr_ok(araddr);

    // Write response, one cycle after the take
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= tccc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? tccc_pkg::RESP_OKAY : tccc_pkg::RESP_DECERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read response; data sampled at the take so side effects match it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= tccc_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            rvalid <= 1'b1;
            rdata <= {24'h000000, rd_byte};
            rresp <= rd_hit ? tccc_pkg::RESP_OKAY : tccc_pkg::RESP_DECERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Read multiplexer; unmapped words read zero
    always_comb begin
        rd_byte = 8'h00;
        case (araddr)
            tccc_pkg::MSC_OFS: rd_byte = msc;
            tccc_pkg::CNTH_OFS: rd_byte = cnt_latched ? cnt_buf[15:8] : cnt[15:8];
            tccc_pkg::CNTL_OFS: rd_byte = cnt_latched ? cnt_buf[7:0] : cnt[7:0];
            tccc_pkg::MODH_OFS: rd_byte = modulo[15:8];
            tccc_pkg::MODL_OFS: rd_byte = modulo[7:0];
            default: rd_byte = 8'h00;
        endcase
        for (int i = 0; i < NUM_CH; i++) begin
            if (araddr == 8'(tccc_pkg::CH_BASE + 8'(i << tccc_pkg::CH_STRIDE_SH))) begin
                rd_byte = {ch_ctl[i], 2'h0};
            end
            if (araddr == 8'(tccc_pkg::CH_BASE + 8'(i << tccc_pkg::CH_STRIDE_SH) +
                tccc_pkg::CH_VH_OFS)) begin
                rd_byte = ch_val[i][15:8];
            end
            if (araddr == 8'(tccc_pkg::CH_BASE + 8'(i << tccc_pkg::CH_STRIDE_SH) +
                tccc_pkg::CH_VL_OFS)) begin
                rd_byte = ch_val[i][7:0];
            end
        end
    end

    // Clock input synchronisers; third stage only serves edge detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
            fix_s1 <= 1'b0;
            fix_s2 <= 1'b0;
            fix_s3 <= 1'b0;
        end else begin
            ext_s1 <= external_timer_clock;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            fix_s1 <= fixed_system_clock;
            fix_s2 <= fix_s1;
            fix_s3 <= fix_s2;
        end
    end
    // Rising edges; an external clock above a quarter bus rate would lose edges
    assign ext_edge = ext_s2 && !ext_s3;
    assign fix_edge = fix_s2 && !fix_s3;

    // Source selection into the prescaler
    always_comb begin
        case (msc.clk_src)
            tccc_pkg::CLKS_BUS: tick_src = 1'b1;
            tccc_pkg::CLKS_FIX: tick_src = fix_edge;
            tccc_pkg::CLKS_EXT: tick_src = ext_edge;
            default: tick_src = 1'b0;
        endcase
    end

    // Prescaler; divide by 2^n as a one-cycle enable
    assign presc_mask = 7'((8'h01 << msc.prescale) - 8'h01);
    assign tick = tick_src && !debug_active && ((presc_cnt & presc_mask) == presc_mask);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_cnt <= tccc_pkg::PRESC_RST;
        end else if (tick_src && !debug_active) begin
            presc_cnt <= presc_cnt + 7'h01;
        end
    end

    // Terminal count; modulo zero means full range
    assign term = (modulo == tccc_pkg::MOD_RST) ? tccc_pkg::TERM_FULL : modulo;
    assign at_term = (cnt == term);
    assign ovf_event = tick && at_term && !dir_down;
    assign ovf_set = ovf_event && !(mod_pend_h || mod_pend_l);

    // Main counter; manual clear by any counter byte write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= tccc_pkg::CNT_RST;
            dir_down <= 1'b0;
        end else if (wr_cnt) begin
            cnt <= tccc_pkg::CNT_RST;
            dir_down <= 1'b0;
        end else if (tick) begin
            if (!msc.center) begin
                cnt <= at_term ? tccc_pkg::CNT_RST : cnt + tccc_pkg::CNT_ONE;
                dir_down <= 1'b0;
            end else if (!dir_down) begin
                cnt <= at_term ? cnt - tccc_pkg::CNT_ONE : cnt + tccc_pkg::CNT_ONE;
                dir_down <= at_term;
            end else if (cnt == tccc_pkg::CNT_RST) begin
                cnt <= tccc_pkg::CNT_ONE;
                dir_down <= 1'b0;
            end else begin
                cnt <= cnt - tccc_pkg::CNT_ONE;
            end
        end
    end

    // Coherent counter read latch, frozen during debug
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_latched <= 1'b0;
            cnt_first_hi <= 1'b0;
            cnt_buf <= tccc_pkg::CNT_RST;
        end else if (wr_cnt || wr_msc) begin
            cnt_latched <= 1'b0;
        end else if ((rd_cnth || rd_cntl) && !debug_active) begin
            if (!cnt_latched) begin
                cnt_latched <= 1'b1;
                cnt_buf <= cnt;
                cnt_first_hi <= rd_cnth;
            end else if (rd_cnth != cnt_first_hi) begin
                cnt_latched <= 1'b0;
            end
        end
    end

    // Modulo bytes; pending marks block overflow until the pair completes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            modulo <= tccc_pkg::MOD_RST;
            mod_pend_h <= 1'b0;
            mod_pend_l <= 1'b0;
        end else if (wr_modh) begin
            modulo[15:8] <= wbyte;
            mod_pend_h <= !mod_pend_l;
            mod_pend_l <= 1'b0;
        end else if (wr_modl) begin
            modulo[7:0] <= wbyte;
            mod_pend_l <= !mod_pend_h;
            mod_pend_h <= 1'b0;
        end
    end

    // Main control fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            msc.ovf_ie <= 1'b0;
            msc.center <= 1'b0;
            msc.clk_src <= tccc_pkg::CLKS_OFF;
            msc.prescale <= 3'h0;
        end else if (wr_msc) begin
            msc.ovf_ie <= wbyte[6];
            msc.center <= wbyte[5];
            msc.clk_src <= wbyte[4:3];
            msc.prescale <= wbyte[2:0];
        end
    end

    // Overflow flag; a new overflow wins over the clear and disarms it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            msc.ovf <= 1'b0;
            ovf_arm <= 1'b0;
        end else begin
            if (ovf_set) begin
                msc.ovf <= 1'b1;
            end else if (wr_msc && ovf_arm && !wbyte[7]) begin
                msc.ovf <= 1'b0;
            end
            if (ovf_set || wr_msc) begin
                ovf_arm <= 1'b0;
            end else if (rd_msc && msc.ovf) begin
                ovf_arm <= 1'b1;
            end
        end
    end
    assign overflow_irq = msc.ovf && msc.ovf_ie;

    // Per-channel logic
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        localparam logic [7:0] BASE = 8'(tccc_pkg::CH_BASE + 8'(g << tccc_pkg::CH_STRIDE_SH));
        tccc_pkg::tccc_chan_mode_t mode;
        logic wr_sc, wr_vh, wr_vl, rd_sc;
        logic pin_prev, rise, fall, cap_event, match, chan_event, arm;
        logic pend_h, pend_l;
        logic [7:0] vbuf;
        logic high_true;

        assign wr_sc = wr_en && (awaddr == BASE + tccc_pkg::CH_SC_OFS);
        assign wr_vh = wr_en && (awaddr == BASE + tccc_pkg::CH_VH_OFS);
        assign wr_vl = wr_en && (awaddr == BASE + tccc_pkg::CH_VL_OFS);
        assign rd_sc = rd_fire && (araddr == BASE + tccc_pkg::CH_SC_OFS);

        // Mode decode; center select overrides every channel
        always_comb begin
            if (msc.center) begin
                mode = tccc_pkg::CH_CPWM;
            end else if (ch_ctl[g].mode_b) begin
                mode = tccc_pkg::CH_EPWM;
            end else if (ch_ctl[g].mode_a) begin
                mode = tccc_pkg::CH_COMPARE;
            end else begin
                mode = tccc_pkg::CH_CAPTURE;
            end
        end

        // Pin edge detection; pin is already synchronous to aclk
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pin_prev <= chan_pin_in[g]; // Track the idle level so no false edge follows reset
            end else begin
                pin_prev <= chan_pin_in[g];
            end
        end
        assign rise = chan_pin_in[g] && !pin_prev;
        assign fall = !chan_pin_in[g] && pin_prev;
        assign cap_event = (mode == tccc_pkg::CH_CAPTURE) &&
            ((ch_ctl[g].els == tccc_pkg::ELS_RISE && rise) ||
             (ch_ctl[g].els == tccc_pkg::ELS_FALL && fall) ||
             (ch_ctl[g].els == tccc_pkg::ELS_BOTH && (rise || fall)));
        // One match per timer clock, so up and down passes both count
        assign match = tick && (cnt == ch_val[g]) && (mode != tccc_pkg::CH_CAPTURE);
        assign chan_event = cap_event || match;
        assign high_true = (ch_ctl[g].els == tccc_pkg::ELS_FALL);

        // Channel control fields
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ch_ctl[g].irq_en <= 1'b0;
                ch_ctl[g].mode_b <= 1'b0;
                ch_ctl[g].mode_a <= 1'b0;
                ch_ctl[g].els <= tccc_pkg::ELS_NONE;
            end else if (wr_sc) begin
                ch_ctl[g].irq_en <= wbyte[6];
                ch_ctl[g].mode_b <= wbyte[5];
                ch_ctl[g].mode_a <= wbyte[4];
                ch_ctl[g].els <= wbyte[3:2];
            end
        end

        // Channel flag with read-then-write-zero clear; events win
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ch_ctl[g].flag <= 1'b0;
                arm <= 1'b0;
            end else begin
                if (chan_event) begin
                    ch_ctl[g].flag <= 1'b1;
                end else if (wr_sc && arm && !wbyte[7]) begin
                    ch_ctl[g].flag <= 1'b0;
                end
                if (chan_event || wr_sc) begin
                    arm <= 1'b0;
                end else if (rd_sc && ch_ctl[g].flag) begin
                    arm <= 1'b1;
                end
            end
        end
        assign chan_irq[g] = ch_ctl[g].flag && ch_ctl[g].irq_en;

        // Value register: capture load or buffered coherent byte-pair write
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ch_val[g] <= tccc_pkg::CNT_RST;
                vbuf <= 8'h00;
                pend_h <= 1'b0;
                pend_l <= 1'b0;
            end else if (cap_event) begin
                ch_val[g] <= cnt;
            end else if (wr_sc) begin
                pend_h <= 1'b0;
                pend_l <= 1'b0;
            end else if (wr_vh) begin
                if (pend_l) begin
                    ch_val[g] <= {wbyte, vbuf};
                end
                vbuf <= wbyte;
                pend_h <= !pend_l;
                pend_l <= 1'b0;
            end else if (wr_vl) begin
                if (pend_h) begin
                    ch_val[g] <= {vbuf, wbyte};
                end
                vbuf <= wbyte;
                pend_l <= !pend_h;
                pend_h <= 1'b0;
            end
        end

        // Output pin action per mode; match takes priority over period start
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                chan_pin_out[g] <= 1'b0;
            end else begin
                case (mode)
                    tccc_pkg::CH_COMPARE: begin
                        if (match) begin
                            case (ch_ctl[g].els)
                                tccc_pkg::ELS_RISE: chan_pin_out[g] <= !chan_pin_out[g];
                                tccc_pkg::ELS_FALL: chan_pin_out[g] <= 1'b0;
                                tccc_pkg::ELS_BOTH: chan_pin_out[g] <= 1'b1;
                                default: chan_pin_out[g] <= chan_pin_out[g];
                            endcase
                        end
                    end
                    tccc_pkg::CH_EPWM: begin
                        if (match) begin
                            chan_pin_out[g] <= !high_true;
                        end else if (ovf_event) begin
                            chan_pin_out[g] <= high_true;
                        end
                    end
                    tccc_pkg::CH_CPWM: begin
                        if (match) begin
                            chan_pin_out[g] <= dir_down ? high_true : !high_true;
                        end
                    end
                    default: chan_pin_out[g] <= chan_pin_out[g];
                endcase
            end
        end
        // Pin released in capture mode and whenever edge/level is 00
        assign chan_pin_oe_n[g] = (ch_ctl[g].els == tccc_pkg::ELS_NONE) ||
            (mode == tccc_pkg::CH_CAPTURE);
    end
endmodule

//--- sim/tccc_sva.sv
// Port checker for the timer block: bus handshakes and reset state
`timescale 1ns/100ps
module tccc_checker #(
    parameter int NUM_CH = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic wvalid,
    input wire logic awready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic [NUM_CH-1:0] chan_pin_oe_n,
    input wire logic overflow_irq,
    input wire logic [NUM_CH-1:0] chan_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Handshake timing as handed over
    property p_aw; awready == (awvalid && wvalid && !bvalid); endproperty
    a_aw: assert property (p_aw) else $error("write accept wrong");
    property p_b; awvalid && awready |=> bvalid; endproperty
    a_b: assert property (p_b) else $error("write response late");
    property p_bh; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_bh: assert property (p_bh) else $error("write response dropped");
    property p_ar; arready == !rvalid; endproperty
    a_ar: assert property (p_ar) else $error("read accept wrong");
    property p_r; arvalid && arready |=> rvalid; endproperty
    a_r: assert property (p_r) else $error("read response late");
    property p_rh; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    a_rh: assert property (p_rh) else $error("read data moved");
    property p_rd; rvalid |-> rdata[31:8] == 24'h000000; endproperty
    a_rd: assert property (p_rd) else $error("upper read bits set");
    // Reset must leave pins released and requests quiet
    property p_rst;
        disable iff (1'b0)
        !aresetn |=> (&chan_pin_oe_n) && !overflow_irq && chan_irq == {NUM_CH{1'b0}};
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    c_wr: cover property (awvalid && awready);
    c_ovf: cover property ($rose(overflow_irq));
    c_cap: cover property ($rose(chan_irq[0]));
endmodule

//--- sim/tccc_pins.sv
// Far-side model: external clocks and channel pin levels
`timescale 1ns/100ps
module tccc_pins (
    input wire logic aclk,
    input wire logic cap,
    output logic external_timer_clock,
    output logic fixed_system_clock,
    output logic [1:0] chan_pin_in
);
    logic [1:0] div = 2'h0;
    // Quarter of the bus rate, the fastest the input may run
    always @(posedge aclk) div <= div + 2'h1;
    assign external_timer_clock = div[1];
    assign fixed_system_clock = div[1];
    // Second pin mirrors the first inverted, so it moves only when the first does
    assign chan_pin_in = {~cap, cap};
endmodule

//--- sim/tccc_top_test.sv
// Self-checking bench for the timer counter block
`timescale 1ns/100ps
module timer_counter_channel_control_test;
    logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, debug_active = 1'h0, cap = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, cfg;
    logic [31:0] wdata = 32'h0, rdata, v, t, c0, c1, i, seed = 32'h3824;
    logic [31:0] miscompares = 32'h0, checks = 32'h0, cyc = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic [2:0] p;
    logic [15:0] a, b;
    logic [1:0] bresp, rresp, chan_pin_in, chan_pin_out, chan_pin_oe_n, chan_irq;
    logic awready, wready, bvalid, arready, rvalid, overflow_irq;
    logic external_timer_clock, fixed_system_clock;
    localparam logic [7:0] RA [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
    tccc_top uut (.*);
    tccc_pins pins (.*);
    always #5 aclk = ~aclk;
    // Hang guard, far above the few thousand cycles needed
    always @(posedge aclk) begin
        cyc <= cyc + 32'h1;
        if (cyc == 32'h4E20) begin
            miscompares++;
            conclude();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected ticks: slow sources rise every fourth bus cycle
    function automatic logic [15:0] ticks(input logic [31:0] c, input logic [1:0] s);
        if (s == tccc_pkg::CLKS_OFF) return 16'h0;
        return 16'(((s == tccc_pkg::CLKS_BUS) ? c : c >> 2) >> p);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= ad;
        wdata <= {24'h000000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do @(posedge aclk); while (awready !== 1'h1);
        awvalid <= 1'h0;
        wvalid <= 1'h0;
        do @(posedge aclk); while (bvalid !== 1'h1);
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [31:0] d);
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge aclk); while (rvalid !== 1'h1);
        d = {rresp, 22'h0, rdata[7:0]};
        rready <= 1'h0;
    endtask
    // Low byte first latches, high byte then comes from the latch
    task automatic rdcnt(output logic [15:0] c);
        logic [31:0] l, h;
        rd(tccc_pkg::CNTL_OFS, l);
        rd(tccc_pkg::CNTH_OFS, h);
        c = {h[7:0], l[7:0]};
    endtask
    task automatic clr();
        rd(tccc_pkg::CH_BASE, v);
        wr(tccc_pkg::CH_BASE, cfg);
        cap <= cap;
    endtask
    // Wait for the channel flag, bounded so a lost event cannot hang
    task automatic waitch();
        i = 32'h0;
        while (chan_irq[0] !== 1'h1 && i < 32'h12C) begin
            @(posedge aclk);
            i++;
        end
    endtask
    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 32'h0 && checks > 32'h0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        for (int k = 0; k < 6; k++) begin
            rd(RA[k], v);
            chk(v, 32'h0);
        end
        rd(8'hFC, v);
        chk(v[31:30], tccc_pkg::RESP_DECERR);
        wr(8'hFC, 8'h00);
        chk(32'(bresp), 32'(tccc_pkg::RESP_DECERR));
        // Every clock source with a random prescale, random spacing
        for (int s = 0; s < 4; s++) begin
            t = rnd();
            p = t[2:0];
            wr(tccc_pkg::MSC_OFS, {3'h0, s[1:0], p});
            c0 = cyc;
            rdcnt(a);
            repeat (100 + t[15:8]) @(posedge aclk);
            c1 = cyc;
            rdcnt(b);
            chk(32'((b - a + 16'h1 - ticks(c1 - c0, s[1:0])) <= 16'h2), 32'h1);
        end
        debug_active <= 1'h1;
        rdcnt(a);
        repeat (50) @(posedge aclk);
        rdcnt(b);
        chk(32'(b), 32'(a));
        debug_active <= 1'h0;
        // Half-written modulo blocks the flag until the pair is complete
        wr(tccc_pkg::MSC_OFS, 8'h48);
        wr(tccc_pkg::CNTL_OFS, 8'h00);
        wr(tccc_pkg::MODH_OFS, 8'h01);
        repeat (600) @(posedge aclk);
        chk(32'(overflow_irq), 32'h0);
        wr(tccc_pkg::MODL_OFS, 8'h00);
        i = 32'h0;
        while (overflow_irq !== 1'h1 && i < 32'h12C) begin
            @(posedge aclk);
            i++;
        end
        chk(32'(overflow_irq), 32'h1);
        wr(tccc_pkg::MSC_OFS, 8'hC8);
        chk(32'(overflow_irq), 32'h1);
        rd(tccc_pkg::MSC_OFS, v);
        wr(tccc_pkg::MSC_OFS, 8'h48);
        chk(32'(overflow_irq), 32'h0);
        // Capture on each edge code, rising then falling pin
        for (int e = 1; e < 4; e++) begin
            cfg = {2'h1, 2'h0, e[1:0], 2'h0};
            clr();
            cap <= 1'h1;
            repeat (4) @(posedge aclk);
            chk(32'(chan_irq[0]), 32'(e[0]));
            clr();
            cap <= 1'h0;
            repeat (4) @(posedge aclk);
            chk(32'(chan_irq[0]), 32'(e[1]));
        end
        // Compare toggle at 0x0080, then edge PWM, then center PWM on the down pass
        wr(tccc_pkg::CH_BASE + tccc_pkg::CH_VH_OFS, 8'h00);
        wr(tccc_pkg::CH_BASE + tccc_pkg::CH_VL_OFS, 8'h80);
        cfg = 8'h54;
        clr();
        waitch();
        rdcnt(a);
        chk(32'(16'(a - 16'h0080) <= 16'h0004), 32'h1);
        chk(32'(chan_pin_out[0]), 32'h1);
        chk(32'(chan_pin_oe_n[0]), 32'h0);
        cfg = 8'h68;
        clr();
        waitch();
        chk(32'(chan_irq[0]), 32'h1);
        chk(32'(chan_pin_out[0]), 32'h0);
        wr(tccc_pkg::MSC_OFS, 8'h68);
        clr();
        waitch();
        chk(32'(chan_pin_out[0]), 32'h1);
        conclude();
    end
endmodule
bind tccc_top tccc_checker #(.NUM_CH(NUM_CH)) chk (.*);
